// ---- core/kts_pkg.sv ----
// Package of constants and carrier types for the keying and test-input controller
package kts_pkg;
  localparam int unsigned CLK_HZ       = 125_000_000;
  localparam int unsigned HOLD_MS      = 10;
  localparam int unsigned HOLD_CYC     = CLK_HZ / 1000 * HOLD_MS;
  localparam int unsigned DIT_MS       = 50;
  localparam int unsigned DIT_CYC      = CLK_HZ / 1000 * DIT_MS;
  localparam int unsigned BAUD         = 9600;
  localparam int unsigned BIT_CYC      = CLK_HZ / BAUD;
  localparam int unsigned GATE_MS      = 1000;
  localparam int unsigned GATE_CYC     = CLK_HZ / 1000 * GATE_MS;
  localparam int unsigned PPS_MIN_US   = 1;
  localparam int unsigned PPS_MIN_CYC  = CLK_HZ / 1_000_000 * PPS_MIN_US * 2;
  localparam logic [1:0]  BTN_CHAN     = 2'h3;
  localparam logic [1:0]  DVM_CHAN     = 2'h2;
  localparam logic [1:0]  AUD_CHAN     = 2'h0;
  localparam logic [1:0]  FILT_CHAN    = 2'h1;
  // Button thresholds: midpoints between 0.00, 3.76, 4.55, 5.00 V on a 5 V, 10-bit scale
  localparam logic [9:0]  BTN_T_LEFT   = 10'h181;
  localparam logic [9:0]  BTN_T_RIGHT  = 10'h353;
  localparam logic [9:0]  BTN_T_CTR    = 10'h3d1;
  localparam logic [9:0]  AUD_ZERO     = 10'h200;
  localparam logic [7:0]  ADDR_CTRL    = 8'h00;
  localparam logic [7:0]  ADDR_STAT    = 8'h04;
  localparam logic [7:0]  ADDR_IMASK   = 8'h08;
  localparam logic [7:0]  ADDR_ISTAT   = 8'h0c;
  localparam logic [7:0]  ADDR_COUNTER_TEST_INPUT    = 8'h10;
  localparam logic [7:0]  ADDR_DVM     = 8'h14;
  localparam logic [7:0]  ADDR_AUDIO   = 8'h18;
  localparam logic [7:0]  ADDR_SGEN    = 8'h1c;
  localparam logic [7:0]  ADDR_GPS     = 8'h20;
  localparam logic [7:0]  ADDR_MENU    = 8'h24;
  localparam logic [2:0]  DIGITS       = 3'h7;
  typedef enum logic [1:0] {KTS_STRAIGHT = 2'h0, KTS_IAMBIC = 2'h1, KTS_BEACON = 2'h2} kts_mode_e;
  typedef enum logic [1:0] {KTS_NONE = 2'h0, KTS_LEFT = 2'h1, KTS_RIGHT = 2'h2, KTS_CTR = 2'h3}
    kts_btn_e;
  typedef enum logic [1:0] {KTS_RX = 2'h0, KTS_KEYED = 2'h1, KTS_HOLD = 2'h3} kts_trx_e;
  typedef struct packed {
    logic [1:0] chan;
    logic       start;
  } kts_adc_req_s;
  typedef struct packed {
    logic       rx_enable;
    logic       tx_mute;
    logic       key_out;
  } kts_trx_s;
endpackage

// ---- core/kts_ctrl.sv ----
// Keying sequencer, button decoder, GPS inputs, counter and meters behind AXI4-Lite
`timescale 1ns/1ns
module kts_ctrl #(
  parameter int unsigned HOLD_CYCLES = kts_pkg::HOLD_CYC,
  parameter int unsigned DIT_CYCLES  = kts_pkg::DIT_CYC,
  parameter int unsigned BIT_CYCLES  = kts_pkg::BIT_CYC,
  parameter int unsigned GATE_CYCLES = kts_pkg::GATE_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic                 dot_pps_in,
  input  wire logic                 dash_serial_in,
  input  wire logic                 button_in,
  input  wire logic                 counter_test_input,
  input  wire logic                 enc_ccw_step,
  output kts_pkg::kts_adc_req_s     adc_req,
  input  wire logic                 adc_done,
  input  wire logic [9:0]           adc_data,
  output kts_pkg::kts_trx_s         trx,
  output logic                      sidetone_en,
  output logic                      practice_ind,
  output logic                      sgen_run,
  output logic                      irq
);
  // Control: [1:0] mode, [2] practice, [3] gps_sel, [4] align, [5] meter_go, [6] test_menu
  logic [31:0] ctrl_r;
  logic [5:0]  imask_r;
  logic [5:0]  istat_r;
  logic [5:0]  ev;
  logic        aw_hold_r;
  logic        w_hold_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic        wr_go;
  logic        dot_d_r;
  logic        dash_d_r;
  logic        btn_d_r;
  logic        cnt_d_r;
  kts_pkg::kts_mode_e mode;
  logic        gps_sel;
  logic        practice;

  function automatic kts_pkg::kts_btn_e btn_class(input logic [9:0] code);
    if (code >= kts_pkg::BTN_T_CTR) return kts_pkg::KTS_CTR;
    if (code >= kts_pkg::BTN_T_RIGHT) return kts_pkg::KTS_RIGHT;
    if (code >= kts_pkg::BTN_T_LEFT) return kts_pkg::KTS_LEFT;
    return kts_pkg::KTS_NONE;
  endfunction

  assign mode     = kts_pkg::kts_mode_e'(ctrl_r[1:0]);
  assign gps_sel  = ctrl_r[3];

  always_ff @(posedge clk) begin
    if (reset) begin
      dot_d_r  <= 1'b0;
      dash_d_r <= 1'b1;
      btn_d_r  <= 1'b0;
      cnt_d_r  <= 1'b0;
    end else begin
      dot_d_r  <= dot_pps_in;
      dash_d_r <= dash_serial_in;
      btn_d_r  <= button_in;
      cnt_d_r  <= counter_test_input;
    end
  end

  // ADC sequencer: button conversions win over meter polls
  logic [1:0]  adc_chan_r;
  logic        adc_start_r;
  logic        adc_busy_r;
  logic        btn_pend_r;
  logic [1:0]  btn_code_r;
  logic [9:0]  dvm_r;
  logic [9:0]  aud_r;
  logic [9:0]  filt_r;
  logic        meter_tgl_r;
  always_ff @(posedge clk) begin
    if (reset) begin
      adc_chan_r  <= 2'h0;
      adc_start_r <= 1'b0;
      adc_busy_r  <= 1'b0;
      btn_pend_r  <= 1'b0;
      btn_code_r  <= 2'h0;
      dvm_r       <= 10'h000;
      aud_r       <= kts_pkg::AUD_ZERO;
      filt_r      <= kts_pkg::AUD_ZERO;
      meter_tgl_r <= 1'b0;
    end else begin
      adc_start_r <= 1'b0;
      if (button_in && !btn_d_r)
        btn_pend_r <= 1'b1;
      if (!adc_busy_r) begin
        if (btn_pend_r) begin
          adc_chan_r  <= kts_pkg::BTN_CHAN;
          adc_start_r <= 1'b1;
          adc_busy_r  <= 1'b1;
          btn_pend_r  <= 1'b0;
        end else if (ctrl_r[5]) begin
          adc_chan_r  <= meter_tgl_r ? kts_pkg::DVM_CHAN
                       : (ctrl_r[4] ? kts_pkg::FILT_CHAN : kts_pkg::AUD_CHAN);
          meter_tgl_r <= ~meter_tgl_r;
          adc_start_r <= 1'b1;
          adc_busy_r  <= 1'b1;
        end
      end else if (adc_done) begin
        adc_busy_r <= 1'b0;
        unique case (adc_chan_r)
          kts_pkg::BTN_CHAN:  btn_code_r <= btn_class(adc_data);
          kts_pkg::DVM_CHAN:  dvm_r <= adc_data;
          kts_pkg::AUD_CHAN:  aud_r <= adc_data;
          kts_pkg::FILT_CHAN: filt_r <= adc_data;
        endcase
      end
    end
  end
  assign adc_req = '{chan: adc_chan_r, start: adc_start_r};

  // Serial receiver on the dash line, 8N1
  logic [31:0] rx_cnt_r;
  logic [3:0]  rx_bit_r;
  logic [7:0]  rx_sh_r;
  logic [7:0]  rx_byte_r;
  logic        rx_act_r;
  logic        rx_stb;
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_cnt_r  <= 32'h0;
      rx_bit_r  <= 4'h0;
      rx_sh_r   <= 8'h00;
      rx_byte_r <= 8'h00;
      rx_act_r  <= 1'b0;
    end else if (!rx_act_r) begin
      if (!dash_serial_in && dash_d_r) begin
        rx_act_r <= 1'b1;
        rx_cnt_r <= 32'(BIT_CYCLES / 2);
        rx_bit_r <= 4'h0;
      end
    end else if (rx_cnt_r != 32'h0) begin
      rx_cnt_r <= rx_cnt_r - 32'h1;
    end else begin
      rx_cnt_r <= 32'(BIT_CYCLES - 1);
      rx_bit_r <= rx_bit_r + 4'h1;
      if (rx_bit_r == 4'h0 && dash_serial_in)
        rx_act_r <= 1'b0; // False start
      else if (rx_bit_r >= 4'h1 && rx_bit_r <= 4'h8)
        rx_sh_r <= {dash_serial_in, rx_sh_r[7:1]};
      else if (rx_bit_r == 4'h9) begin
        rx_act_r <= 1'b0;
        if (dash_serial_in)
          rx_byte_r <= rx_sh_r;
      end
    end
  end
  assign rx_stb = rx_act_r && rx_cnt_r == 32'h0 && rx_bit_r == 4'h9 && dash_serial_in;

  // Auto practice: a valid frame on the paddle line protects the PA
  logic auto_prac_r;
  always_ff @(posedge clk) begin
    if (reset)
      auto_prac_r <= 1'b0;
    else if (rx_stb && !ctrl_r[2])
      auto_prac_r <= 1'b1;
    else if (wr_go && awaddr_r == kts_pkg::ADDR_CTRL && wdata_r[2])
      auto_prac_r <= 1'b0;
  end
  assign practice     = ctrl_r[2] | auto_prac_r;
  assign practice_ind = practice;

  // Pulse-per-second: second timed from the rising edge
  logic [31:0] pps_run_r;
  logic [31:0] pps_period_r;
  logic [31:0] pps_wid_r;
  logic        pps_stb;
  always_ff @(posedge clk) begin
    if (reset) begin
      pps_run_r    <= 32'h0;
      pps_period_r <= 32'h0;
      pps_wid_r    <= 32'h0;
    end else begin
      pps_run_r <= pps_run_r + 32'h1;
      pps_wid_r <= dot_pps_in ? pps_wid_r + 32'h1 : 32'h0;
      if (pps_stb) begin
        pps_period_r <= pps_run_r;
        pps_run_r    <= 32'h1;
      end
    end
  end
  // Only the paddle dot line in GPS use carries the pulse
  assign pps_stb = gps_sel && dot_pps_in && !dot_d_r;

  // Frequency counter gated by a one-second window
  logic [31:0] gate_r;
  logic [31:0] edges_r;
  logic [31:0] counter_test_input_r;
  logic        gate_stb;
  assign gate_stb = gate_r == 32'(GATE_CYCLES - 1);
  always_ff @(posedge clk) begin
    if (reset) begin
      gate_r  <= 32'h0;
      edges_r <= 32'h0;
      counter_test_input_r  <= 32'h0;
    end else begin
      gate_r <= gate_stb ? 32'h0 : gate_r + 32'h1;
      // Sampled edges: above half of the clock the count aliases
      if (gate_stb) begin
        counter_test_input_r  <= edges_r + {31'h0, counter_test_input & ~cnt_d_r};
        edges_r <= 32'h0;
      end else if (counter_test_input && !cnt_d_r)
        edges_r <= edges_r + 32'h1;
    end
  end

  // Element timer for keyer and beacon modes
  logic [31:0] el_cnt_r;
  logic        el_key_r;
  logic        el_gap_r;
  logic [1:0]  el_len_r;
  logic        el_req;
  logic        dash_p;
  assign dash_p = ~dash_serial_in & ~gps_sel;
  assign el_req = (mode == kts_pkg::KTS_BEACON) ? ctrl_r[7]
                : (~dot_pps_in & ~gps_sel) | dash_p;
  always_ff @(posedge clk) begin
    if (reset) begin
      el_cnt_r <= 32'h0;
      el_key_r <= 1'b0;
      el_gap_r <= 1'b0;
      el_len_r <= 2'h0;
    end else if (el_cnt_r != 32'h0) begin
      el_cnt_r <= el_cnt_r - 32'h1;
    end else if (el_key_r) begin
      el_key_r <= 1'b0;
      el_gap_r <= 1'b1;
      el_cnt_r <= 32'(DIT_CYCLES - 1);
    end else if (el_req && mode != kts_pkg::KTS_STRAIGHT) begin
      el_key_r <= 1'b1;
      el_gap_r <= 1'b0;
      el_len_r <= dash_p ? 2'h3 : 2'h1;
      // Exact dit: DIT_CYCLES of high, dash three times that
      el_cnt_r <= dash_p ? 32'(3 * DIT_CYCLES - 1) : 32'(DIT_CYCLES - 1);
    end else
      el_gap_r <= 1'b0;
  end

  logic key_src;
  assign key_src = (mode == kts_pkg::KTS_STRAIGHT) ? (~dot_pps_in & ~gps_sel) : el_key_r;

  // Transmit/receive sequencer
  kts_pkg::kts_trx_e trx_st_r;
  logic [31:0]       hold_r;
  logic              key_r;
  always_ff @(posedge clk) begin
    if (reset) begin
      trx_st_r <= kts_pkg::KTS_RX;
      hold_r   <= 32'h0;
      key_r    <= 1'b0;
    end else begin
      key_r <= key_src & ~practice;
      unique case (trx_st_r)
        kts_pkg::KTS_RX:
          if (key_src && !practice)
            trx_st_r <= kts_pkg::KTS_KEYED;
        kts_pkg::KTS_KEYED:
          if (!key_r) begin
            trx_st_r <= kts_pkg::KTS_HOLD;
            hold_r   <= 32'(HOLD_CYCLES - 1);
          end
        kts_pkg::KTS_HOLD:
          if (key_r)
            trx_st_r <= kts_pkg::KTS_KEYED;
          else if (hold_r == 32'h0)
            trx_st_r <= kts_pkg::KTS_RX;
          else
            hold_r <= hold_r - 32'h1;
        default:
          trx_st_r <= kts_pkg::KTS_RX;
      endcase
    end
  end
  assign trx.key_out   = key_r;
  assign trx.rx_enable = trx_st_r == kts_pkg::KTS_RX;
  assign trx.tx_mute   = ~trx.rx_enable;
  assign sidetone_en   = practice ? key_src : key_r;

  // Signal generator and menu: cursor 0 is the leftmost digit
  logic [2:0] cursor_r;
  logic       edit_r;
  logic       sgen_r;
  logic       item95_r;
  logic       sel_stb;
  logic       exit_stb;
  logic       btn_stb;
  assign btn_stb  = adc_busy_r && adc_done && adc_chan_r == kts_pkg::BTN_CHAN;
  assign sel_stb  = btn_stb && btn_class(adc_data) == kts_pkg::KTS_LEFT;
  assign exit_stb = btn_stb && btn_class(adc_data) == kts_pkg::KTS_RIGHT;
  always_ff @(posedge clk) begin
    if (reset) begin
      cursor_r <= 3'h0;
      edit_r   <= 1'b0;
      sgen_r   <= 1'b0;
      item95_r <= 1'b0;
    end else begin
      if (exit_stb) begin
        edit_r <= 1'b0;
        if (!edit_r)
          sgen_r <= 1'b0;
      end else if (sel_stb && ctrl_r[6] && !item95_r) begin
        if (!edit_r) begin
          edit_r   <= 1'b1;
          sgen_r   <= 1'b1;
          cursor_r <= 3'h0;
        end else if (cursor_r == kts_pkg::DIGITS - 3'h1)
          edit_r <= 1'b0;
        else
          cursor_r <= cursor_r + 3'h1;
      end
      if (enc_ccw_step && ctrl_r[6] && !edit_r && !item95_r)
        item95_r <= 1'b1;
      else if (!ctrl_r[6] || exit_stb)
        item95_r <= 1'b0;
    end
  end
  assign sgen_run = sgen_r;

  // Interrupt events: button, rx byte, pps, gate, auto practice, keyed
  assign ev = {trx_st_r == kts_pkg::KTS_RX && key_src && !practice,
               rx_stb && !ctrl_r[2], gate_stb, pps_stb, rx_stb, btn_stb};
  always_ff @(posedge clk) begin
    if (reset)
      istat_r <= 6'h00;
    else if (wr_go && awaddr_r == kts_pkg::ADDR_ISTAT)
      istat_r <= (istat_r & ~wdata_r[5:0]) | ev; // Set wins over clear
    else
      istat_r <= istat_r | ev;
  end
  assign irq = |(istat_r & imask_r);

  // AXI4-Lite write: address and data in either order
  assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_r && !s_axi_bvalid;
  assign wr_go = aw_hold_r && w_hold_r;
  always_ff @(posedge clk) begin
    if (reset) begin
      aw_hold_r    <= 1'b0;
      w_hold_r     <= 1'b0;
      awaddr_r     <= 8'h00;
      wdata_r      <= 32'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
      ctrl_r       <= 32'h0;
      imask_r      <= 6'h00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
      end
      if (wr_go) begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'h0;
        unique case (awaddr_r)
          kts_pkg::ADDR_CTRL:  ctrl_r <= {24'h0, wdata_r[7:0]};
          kts_pkg::ADDR_IMASK: imask_r <= wdata_r[5:0];
          kts_pkg::ADDR_ISTAT: ;
          default:             s_axi_bresp <= 2'h2;
        endcase
      end else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // AXI4-Lite read
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'h0;
      unique case (s_axi_araddr)
        kts_pkg::ADDR_CTRL:  s_axi_rdata <= ctrl_r;
        kts_pkg::ADDR_STAT:  s_axi_rdata <= {20'h0, btn_code_r, el_len_r, el_gap_r, practice,
                                             auto_prac_r, trx.key_out, trx.tx_mute,
                                             trx.rx_enable, trx_st_r};
        kts_pkg::ADDR_IMASK: s_axi_rdata <= {26'h0, imask_r};
        kts_pkg::ADDR_ISTAT: s_axi_rdata <= {26'h0, istat_r};
        kts_pkg::ADDR_COUNTER_TEST_INPUT:  s_axi_rdata <= counter_test_input_r;
        kts_pkg::ADDR_DVM:   s_axi_rdata <= {22'h0, dvm_r};
        kts_pkg::ADDR_AUDIO: s_axi_rdata <= {6'h0, filt_r, 6'h0, aud_r};
        kts_pkg::ADDR_SGEN:  s_axi_rdata <= {26'h0, item95_r, cursor_r, edit_r, sgen_r};
        kts_pkg::ADDR_GPS:   s_axi_rdata <= pps_period_r;
        kts_pkg::ADDR_MENU:  s_axi_rdata <= {23'h0, pps_wid_r >= 32'(kts_pkg::PPS_MIN_CYC),
                                             rx_byte_r};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  sequence s_keyfall;
    trx_st_r == kts_pkg::KTS_KEYED && !key_r;
  endsequence
  a_rx_hold_low: assert property (@(posedge clk) disable iff (reset)
    s_keyfall ##1 !key_r |-> !trx.rx_enable) else $error("Receive enabled during hold");
  a_mute_inverse: assert property (@(posedge clk) disable iff (reset)
    trx.tx_mute != trx.rx_enable) else $error("Mute not inverse of receive");
  a_practice_safe: assert property (@(posedge clk) disable iff (reset)
    practice && $past(practice) |-> !trx.key_out) else $error("Keyed in practice");
  a_hold_release: assert property (@(posedge clk) disable iff (reset)
    trx_st_r == kts_pkg::KTS_HOLD && hold_r == 32'h0 && !key_r |=> trx.rx_enable)
    else $error("Receive did not return after hold");
  a_btn_chan: assert property (@(posedge clk) disable iff (reset)
    !adc_busy_r && btn_pend_r |=> adc_req.start && adc_req.chan == kts_pkg::BTN_CHAN)
    else $error("Button conversion not on channel 3");
  a_auto_practice: assert property (@(posedge clk) disable iff (reset)
    rx_stb |=> practice_ind) else $error("Practice not forced");
  a_dit_start: assert property (@(posedge clk) disable iff (reset)
    $rose(el_key_r) && el_len_r == 2'h1 |-> el_cnt_r == 32'(DIT_CYCLES - 1))
    else $error("Dit length wrong");
  a_straight_key: assert property (@(posedge clk) disable iff (reset)
    mode == kts_pkg::KTS_STRAIGHT && !practice && !gps_sel |=> key_r == !$past(dot_pps_in))
    else $error("Straight key not followed");
endmodule

// ---- sim/kts_adc_model.sv ----
// Converter model: answers each start after a chosen delay with the level of the channel asked, the audio level for channels 0 and 1
`timescale 1ns/1ns
module kts_adc_model (
  input  wire logic                  clk,
  input  kts_pkg::kts_adc_req_s      adc_req,
  input  wire logic [9:0]            btn_lvl,
  input  wire logic [9:0]            dvm_lvl,
  input  wire logic [9:0]            aud_lvl,
  input  wire logic [2:0]            lat,
  output logic                       adc_done,
  output logic [9:0]                 adc_data
);
  logic [1:0] chan_r = 2'h0;
  logic [3:0] cnt_r  = 4'h0;
  initial adc_done = 1'b0;
  initial adc_data = 10'h000;
  always @(posedge clk) begin
    adc_done <= 1'b0;
    // Data is good only with the done pulse, so it is scrambled after it
    if (adc_done) adc_data <= ~adc_data;
    if (adc_req.start) begin
      chan_r <= adc_req.chan;
      cnt_r  <= {1'b0, lat} + 4'h1;
    end else if (cnt_r == 4'h1) begin
      adc_done <= 1'b1;
      cnt_r    <= 4'h0;
      if (chan_r == 2'h3) adc_data <= btn_lvl;
      else if (chan_r == 2'h2) adc_data <= dvm_lvl;
      else adc_data <= aud_lvl;
    end else if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
  end
endmodule

// ---- sim/tb_top.sv ----
// Self-checking bench: bus tasks, paddle and serial stimulus, reference model
`timescale 1ns/1ns
module tb_top;
  localparam int HC = 20;
  localparam int DC = 10;
  localparam int BC = 16;
  localparam int GC = 100;
  logic        clk = 1'b0, reset = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, dot = 1'b1, dash = 1'b1, btn = 1'b0;
  logic        ctin = 1'b0, enc = 1'b0, awready, wready, bvalid, arready, rvalid;
  logic        adc_done, sidetone_en, practice_ind, sgen_run, irq;
  logic [1:0]  bresp, rresp, r, ph = 2'h0;
  logic [2:0]  lat = 3'h0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [9:0]  btn_lvl = 10'h000, dvm_lvl = 10'h000, aud_lvl = 10'h000, adc_data;
  logic [31:0] wdata = 32'h0, rdata, d;
  kts_pkg::kts_adc_req_s adc_req;
  kts_pkg::kts_trx_s     trx;
  int          err_total = 0, num_checks = 0, seed, n, i;
  byte unsigned sent [$];
  kts_ctrl #(.HOLD_CYCLES(HC), .DIT_CYCLES(DC), .BIT_CYCLES(BC), .GATE_CYCLES(GC)) u_dut (
    .clk, .reset, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .dot_pps_in(dot), .dash_serial_in(dash),
    .button_in(btn), .counter_test_input(ctin), .enc_ccw_step(enc), .adc_req, .adc_done,
    .adc_data, .trx, .sidetone_en, .practice_ind, .sgen_run, .irq);
  kts_adc_model u_adc (.clk, .adc_req, .btn_lvl, .dvm_lvl, .aud_lvl, .lat, .adc_done, .adc_data);
  always #4 clk = ~clk;
  // Test input at a quarter of the clock, inside the counter's valid range
  always @(posedge clk) begin
    ph   <= ph + 2'h1;
    ctin <= ph[1];
  end
  // Distance kept in code-times-5000 units so no rounding decides a near tie
  function automatic int span(input int code, input int mv);
    int v;
    v = code * 5000 - mv * 1023;
    return (v < 0) ? -v : v;
  endfunction
  function automatic logic [1:0] btn_model(input int code);
    int best, k;
    int nom [4];
    nom  = '{0, 3760, 4550, 5000};
    best = 0;
    for (k = 1; k < 4; k++) if (span(code, nom[k]) < span(code, nom[best])) best = k;
    return best[1:0];
  endfunction
  task automatic final_report();
    if (err_total == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tmo(input int k, input int lim);
    if (k >= lim) begin
      err_total++;
      final_report();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    int k;
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (k = 0; k < 50 && !(bvalid && !awvalid && !wvalid); k++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    tmo(k, 50);
    chk(bresp, er);
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
    int k;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (k = 0; k < 50 && !(rvalid && !arvalid); k++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end
    v = rdata;
    rr = rresp;
    rready <= 1'b0;
    tmo(k, 50);
    @(posedge clk);
  endtask
  task automatic wkey(input logic lvl);
    for (n = 0; n < 99 && trx.key_out !== lvl; n++) @(posedge clk);
    tmo(n, 99);
  endtask
  task automatic wrx();
    for (n = 0; n < 999 && !trx.rx_enable; n++) @(posedge clk);
    tmo(n, 999);
  endtask
  task automatic press(input logic [9:0] lvl);
    btn_lvl <= lvl;
    btn     <= 1'b1;
    for (n = 0; n < 20 && !adc_req.start; n++) @(posedge clk);
    tmo(n, 20);
    chk(adc_req.chan, kts_pkg::BTN_CHAN);
    repeat (12) @(posedge clk);
    btn <= 1'b0;
    @(posedge clk);
  endtask
  // Serial frame, start bit, eight data bits from the lowest, stop bit
  task automatic tx_byte(input byte unsigned b);
    sent.push_back(b);
    dash <= 1'b0;
    repeat (BC) @(posedge clk);
    for (int k = 0; k < 8; k++) begin
      dash <= b[k];
      repeat (BC) @(posedge clk);
    end
    dash <= 1'b1;
    repeat (3 * BC) @(posedge clk);
  endtask
  initial begin
    seed = 32'h99496bc9;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk(trx, 3'b100);
    wr(kts_pkg::ADDR_CTRL, 32'h0, 2'h0);
    dot <= 1'b0;
    wkey(1'b1);
    @(posedge clk);
    chk(trx, 3'b011);
    dot <= 1'b1;
    wkey(1'b0);
    for (n = 0; n < 99 && !trx.rx_enable; n++) @(posedge clk);
    chk(n, HC + 1);
    wr(kts_pkg::ADDR_CTRL, 32'h1, 2'h0);
    dot <= 1'b0;
    wkey(1'b1);
    dot <= 1'b1;
    for (n = 0; n < 99 && trx.key_out; n++) @(posedge clk);
    chk(n, DC);
    wrx();
    wr(kts_pkg::ADDR_CTRL, 32'h82, 2'h0);
    wkey(1'b1);
    chk(trx.rx_enable, 1'b0);
    wr(kts_pkg::ADDR_CTRL, 32'h0, 2'h0);
    wrx();
    wr(kts_pkg::ADDR_ISTAT, 32'h3f, 2'h0);
    for (i = 0; i < 6; i++) begin
      wr(kts_pkg::ADDR_IMASK, {31'h0, i != 0}, 2'h0);
      lat     <= 3'($random(seed));
      press(10'($random(seed)));
      rd(kts_pkg::ADDR_STAT, d, r);
      chk(d[11:10], btn_model(btn_lvl));
      chk(irq, i != 0);
      wr(kts_pkg::ADDR_ISTAT, 32'h1, 2'h0);
      chk(irq, 1'b0);
    end
    wr(8'h3c, 32'h5, 2'h2);
    rd(8'h3c, d, r);
    chk({r, d[29:0]}, 32'h80000000);
    dvm_lvl <= 10'($random(seed));
    aud_lvl <= 10'($random(seed));
    wr(kts_pkg::ADDR_CTRL, 32'h20, 2'h0);
    repeat (200) @(posedge clk);
    rd(kts_pkg::ADDR_DVM, d, r);
    chk(d[9:0], dvm_lvl);
    rd(kts_pkg::ADDR_AUDIO, d, r);
    chk(d, {6'h0, 10'h200, 6'h0, aud_lvl});
    // Generator menu: left is select, right is exit, seven digits to walk
    wr(kts_pkg::ADDR_CTRL, 32'h40, 2'h0);
    press(10'h300);
    chk(sgen_run, 1'b1);
    repeat (7) press(10'h300);
    rd(kts_pkg::ADDR_SGEN, d, r);
    chk(d, 32'h19);
    enc <= 1'b1;
    @(posedge clk);
    enc <= 1'b0;
    press(10'h300);
    rd(kts_pkg::ADDR_SGEN, d, r);
    chk(d, 32'h39);
    press(10'h3a0);
    rd(kts_pkg::ADDR_SGEN, d, r);
    chk(d, 32'h18);
    chk(sgen_run, 1'b0);
    wr(kts_pkg::ADDR_CTRL, 32'h0, 2'h0);
    for (i = 0; i < 2; i++) begin
      wr(kts_pkg::ADDR_ISTAT, 32'h8, 2'h0);
      for (n = 0; n < 60; n++) begin
        rd(kts_pkg::ADDR_ISTAT, d, r);
        if (d[3]) break;
      end
      tmo(n, 60);
    end
    rd(kts_pkg::ADDR_COUNTER_TEST_INPUT, d, r);
    chk(d, GC / 4);
    tx_byte(8'($random(seed)));
    chk(practice_ind, 1'b1);
    dot <= 1'b0;
    repeat (5) @(posedge clk);
    chk({trx.rx_enable, trx.key_out, sidetone_en}, 3'b101);
    dot <= 1'b1;
    wr(kts_pkg::ADDR_CTRL, 32'h8, 2'h0);
    // Two pulses whose rising edges stand 40 cycles apart
    repeat (2) begin
      dot <= 1'b0;
      repeat (4) @(posedge clk);
      dot <= 1'b1;
      repeat (36) @(posedge clk);
    end
    tx_byte(8'($random(seed)));
    rd(kts_pkg::ADDR_MENU, d, r);
    chk(d[7:0], sent[$]);
    rd(kts_pkg::ADDR_GPS, d, r);
    chk(d, 32'd40);
    final_report();
  end
endmodule
